// File: ipw_pkg.sv
// Package for the indexed-port watchdog: port addresses, index map, fields, timing.
// Assumes a 25 MHz system clock.
package ipw_pkg;
    localparam logic [7:0]  IDX_PORT_ADDR     = 8'h2e;
    localparam logic [7:0]  DATA_PORT_ADDR    = 8'h2f;
    localparam logic [7:0]  UNLOCK_KEY        = 8'h87;
    localparam logic [7:0]  LOCK_KEY          = 8'haa;
    localparam logic [7:0]  LDEV_SELECT_IDX   = 8'h07;
    localparam logic [7:0]  FUNC_ACTIVATE_IDX = 8'h30;
    localparam logic [7:0]  COUNT_UNIT_IDX    = 8'hf5;
    localparam logic [7:0]  TIMEOUT_COUNT_IDX = 8'hf6;
    localparam logic [7:0]  WDT_CTRL_IDX      = 8'hf7;
    localparam logic [7:0]  WDT_LDEV_NUM      = 8'h08;
    localparam int          ACTIVATE_BIT      = 0;
    localparam int          UNIT_MINUTE_BIT   = 3;
    localparam int          UNIT_FAST_BIT     = 4;
    localparam int          KBD_RELOAD_BIT    = 6;
    localparam int          FORCE_TIMEOUT_BIT = 5;
    localparam int          TIMEOUT_STAT_BIT  = 4;
    localparam logic [7:0]  RESET_BYTE        = 8'h00;
    localparam int          CLOCK_HZ          = 25000000;
    localparam int          MS_TIME_US        = 1000;
    localparam int          CYCLES_PER_MS     = CLOCK_HZ / 1000000 * MS_TIME_US;
    localparam int          MS_PER_SECOND     = 1000;
    localparam int          SECONDS_PER_MIN   = 60;
    localparam int          FAST_FACTOR       = 1000;
endpackage

// File: ipw_tick_div.sv
// Divider producing a one-cycle enable pulse every DIV_COUNT enables.
// Assumes pulse_in is synchronous to clock_in.
`timescale 1ns/100ps
module ipw_tick_div #(
    parameter int DIV_COUNT = 1000
) (
    input  wire logic clock_in,  // System clock
    input  wire logic rstn_in,   // Synchronous reset, low
    input  wire logic clear_in,  // Restart phase
    input  wire logic pulse_in,  // Input enable
    output logic      tick_out   // One-cycle output enable
);
    localparam int W = (DIV_COUNT > 1) ? $clog2(DIV_COUNT) : 1;
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_tick;

    // Refused at elaboration: a divider below one cannot count
    if (DIV_COUNT < 1)
    begin
        $error("DIV_COUNT must be at least 1");
    end

    always_comb
    begin
        next_count = count;
        next_tick  = 1'b0;
        if (clear_in)
            next_count = '0;
        else if (pulse_in)
        begin
            if (count == W'(DIV_COUNT - 1))
            begin
                next_count = '0;
                next_tick  = 1'b1;
            end
            else
                next_count = count + W'(1);
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            count    <= '0;
            tick_out <= 1'b0;
        end
        else
        begin
            count    <= next_count;
            tick_out <= next_tick;
        end
    end
endmodule

// File: ipw_timebase.sv
// Time base: chains dividers into ms, s and min ticks and picks the unit.
// Assumes one clock; all outputs are one-cycle enables on clock_in.
`timescale 1ns/100ps
module ipw_timebase
    import ipw_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input  wire logic clock_in,  // System clock
    input  wire logic rstn_in,   // Synchronous reset, low
    input  wire logic clear_in,  // Restart all phases
    input  wire logic minute_in, // Unit is minutes
    input  wire logic fast_in,   // 1000 times faster
    output logic      tick_out   // Selected unit tick
);
    logic ms_tick;
    logic sec_tick;
    logic min_tick;
    logic milli_min_tick;

    ipw_tick_div #(.DIV_COUNT(MS_CYCLES)) u_ms (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .clear_in (clear_in),
        .pulse_in (1'b1),
        .tick_out (ms_tick)
    );
    ipw_tick_div #(.DIV_COUNT(MS_PER_SECOND)) u_sec (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .clear_in (clear_in),
        .pulse_in (ms_tick),
        .tick_out (sec_tick)
    );
    ipw_tick_div #(.DIV_COUNT(SECONDS_PER_MIN)) u_min (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .clear_in (clear_in),
        .pulse_in (sec_tick),
        .tick_out (min_tick)
    );
    // Thousandth of a minute is 60 ms
    ipw_tick_div #(.DIV_COUNT(SECONDS_PER_MIN)) u_mmin (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .clear_in (clear_in),
        .pulse_in (ms_tick),
        .tick_out (milli_min_tick)
    );

    always_comb
    begin
        case ({minute_in, fast_in})
            2'b00:   tick_out = sec_tick;
            2'b01:   tick_out = ms_tick;
            2'b10:   tick_out = min_tick;
            default: tick_out = milli_min_tick;
        endcase
    end
endmodule

// File: ipw_watchdog.sv
// Indexed-port watchdog timer: index/data I/O decode, config lock, countdown.
// Assumes I/O strobes are one-cycle pulses synchronous to clock_in; kbd pin is async.
// Contract
// (R1) Decode an index port and a data port reaching the last indexed register.
// (R2) Host writes the index before every data port access.
// (R3) Two successive 87 hex index writes unlock the configuration space.
// (R4) Writing 08 to index 07 selects the watchdog register set.
// (R5) Writing bit 0 of index 30 enables the watchdog.
// (R6) Watchdog is disabled after reset until software enables it.
// (R7) Unit register bit 3 chooses seconds (0, default) or minutes (1).
// (R8) Unit register bit 4 makes counting 1000 times faster.
// (R9) Count value zero stops the timer; zero after reset.
// (R10) Count 01 to FF sets timeout length in selected units.
// (R11) Expiry without refresh raises the timeout output.
// (R12) Each count register write restarts countdown from the new value.
// (R13) Control bit 6 lets keyboard activity reload the timer.
// (R14) Control bit 5 write forces timeout at once and self-clears; the logic forces it only while the watchdog is enabled (index 30 bit 0).
// (R15) Control bit 4 reads one once timeout has been reached.
// (R16) Writing AA hex to the index port locks configuration again.
// (R17) Data writes are ignored while configuration is locked.
// (R18) Enabled nonzero count decrements per tick; zero signals timeout.
`timescale 1ns/100ps
module ipw_watchdog
    import ipw_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input  wire logic       clock_in,     // System clock, 25 MHz
    input  wire logic       rstn_in,      // Synchronous reset, low
    input  wire logic [7:0] io_addr_in,   // I/O port address
    input  wire logic [7:0] io_wdata_in,  // I/O write data
    input  wire logic       io_wr_in,     // I/O write strobe, one cycle
    input  wire logic       io_rd_in,     // I/O read strobe, one cycle
    input  wire logic       kbd_act_in,   // Keyboard activity, async level
    output logic [7:0]      io_rdata_out, // I/O read data, registered
    output logic            io_rvld_out,  // Read data valid, one cycle
    output logic            timeout_out   // Timeout reset/interrupt level
);
    import ipw_pkg::*;

    // Refused at elaboration: the millisecond divider needs one cycle at least
    if (MS_CYCLES < 1)
    begin
        $error("MS_CYCLES must be at least 1");
    end

    typedef enum logic [1:0] {LOCKED, KEY_ONE, UNLOCKED} ipw_lock_t;

    ipw_lock_t  lock_state;
    ipw_lock_t  next_lock_state;
    logic [7:0] index;
    logic [7:0] next_index;
    logic [7:0] ldev;
    logic [7:0] next_ldev;
    logic       active;
    logic       next_active;
    logic [7:0] unit_cfg;
    logic [7:0] next_unit_cfg;
    logic [7:0] count_reload;
    logic [7:0] next_count_reload;
    logic [7:0] count;
    logic [7:0] next_count;
    logic       kbd_en;
    logic       next_kbd_en;
    logic       timed_out;
    logic       next_timed_out;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       rvld;
    logic       next_rvld;
    logic       kbd_sync1;
    logic       kbd_sync2;
    logic       kbd_prev;
    logic       unit_tick;
    logic       restart;

    wire idx_wr  = io_wr_in && (io_addr_in == IDX_PORT_ADDR);   // [R1]
    wire data_wr = io_wr_in && (io_addr_in == DATA_PORT_ADDR);  // [R1]
    wire data_rd = io_rd_in && (io_addr_in == DATA_PORT_ADDR);  // [R1]
    wire cfg_open = (lock_state == UNLOCKED);
    wire wdt_sel  = (ldev == WDT_LDEV_NUM);
    // Locked space drops writes so stray traffic on the port cannot arm it
    wire wr_ok    = data_wr && cfg_open;                        // [R17]
    wire wr_wdt   = wr_ok && wdt_sel;
    wire kbd_edge = kbd_sync2 && !kbd_prev;
    wire count_wr = wr_wdt && (index == TIMEOUT_COUNT_IDX);
    wire ctrl_wr  = wr_wdt && (index == WDT_CTRL_IDX);
    wire force_to = ctrl_wr && io_wdata_in[FORCE_TIMEOUT_BIT];  // [R14]
    wire expiring = active && (count == 8'h01) && unit_tick;    // [R11]

    // Restarting phase on reload makes the first unit a full unit
    assign restart = count_wr || (kbd_en && kbd_edge);

    ipw_timebase #(.MS_CYCLES(MS_CYCLES)) u_timebase (
        .clock_in  (clock_in),
        .rstn_in   (rstn_in),
        .clear_in  (restart),
        .minute_in (unit_cfg[UNIT_MINUTE_BIT]),                 // [R7]
        .fast_in   (unit_cfg[UNIT_FAST_BIT]),                   // [R8]
        .tick_out  (unit_tick)
    );

    // Lock sequencer
    always_comb
    begin
        next_lock_state = lock_state;
        next_index      = index;
        if (idx_wr)
        begin
            if (io_wdata_in == LOCK_KEY)
                next_lock_state = LOCKED;                       // [R16]
            else
            begin
                case (lock_state)
                    LOCKED:
                        next_lock_state = (io_wdata_in == UNLOCK_KEY) ? KEY_ONE : LOCKED;
                    KEY_ONE:
                        next_lock_state = (io_wdata_in == UNLOCK_KEY) ? UNLOCKED : LOCKED; // [R3]
                    default:
                        next_lock_state = UNLOCKED;
                endcase
                if (lock_state == UNLOCKED)
                    next_index = io_wdata_in;                   // [R1]
            end
        end
    end

    // Configuration registers
    always_comb
    begin
        next_ldev         = ldev;
        next_active       = active;
        next_unit_cfg     = unit_cfg;
        next_count_reload = count_reload;
        next_kbd_en       = kbd_en;
        if (wr_ok && index == LDEV_SELECT_IDX)
            next_ldev = io_wdata_in;                            // [R4]
        if (wr_wdt)
        begin
            if (index == FUNC_ACTIVATE_IDX)
                next_active = io_wdata_in[ACTIVATE_BIT];        // [R5]
            else if (index == COUNT_UNIT_IDX)
                next_unit_cfg = io_wdata_in;
            else if (index == TIMEOUT_COUNT_IDX)
                next_count_reload = io_wdata_in;
            else if (index == WDT_CTRL_IDX)
                next_kbd_en = io_wdata_in[KBD_RELOAD_BIT];      // [R13]
        end
    end

    // Countdown and timeout status
    always_comb
    begin
        next_count     = count;
        next_timed_out = timed_out;
        if (count_wr)
        begin
            next_count = io_wdata_in;                           // [R12]
            // Expiry in the same cycle keeps its status: set wins
            if (io_wdata_in != 8'h00)
                next_timed_out = expiring;
        end
        else if (kbd_en && kbd_edge && active)
            next_count = count_reload;                          // [R13]
        else if (active && count != 8'h00 && unit_tick)
        begin
            next_count = count - 8'h01;                         // [R18] [R10]
            if (count == 8'h01)
                next_timed_out = 1'b1;                          // [R18] [R11]
        end
        // Zero count holds, so the timer is stopped [R9]
        // Status clears only via a nonzero count write; a control write leaves it
        if (force_to && active)
            next_timed_out = 1'b1;                              // [R14]
    end

    // Read path
    always_comb
    begin
        next_rdata = RESET_BYTE;
        next_rvld  = 1'b0;
        if (io_rd_in && io_addr_in == IDX_PORT_ADDR)
        begin
            next_rvld  = 1'b1;
            next_rdata = cfg_open ? index : RESET_BYTE;
        end
        else if (data_rd)
        begin
            next_rvld = 1'b1;
            if (cfg_open && index == LDEV_SELECT_IDX)
                next_rdata = ldev;
            else if (cfg_open && wdt_sel)
            begin
                if (index == FUNC_ACTIVATE_IDX)
                    next_rdata = {7'h00, active};
                else if (index == COUNT_UNIT_IDX)
                    next_rdata = unit_cfg;
                else if (index == TIMEOUT_COUNT_IDX)
                    next_rdata = count;
                else if (index == WDT_CTRL_IDX)
                begin
                    next_rdata = RESET_BYTE;
                    next_rdata[KBD_RELOAD_BIT]   = kbd_en;
                    next_rdata[TIMEOUT_STAT_BIT] = timed_out;   // [R15]
                end
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            lock_state   <= LOCKED;
            index        <= RESET_BYTE;
            ldev         <= RESET_BYTE;
            active       <= 1'b0;                               // [R6]
            unit_cfg     <= RESET_BYTE;                         // [R7]
            count_reload <= RESET_BYTE;
            count        <= RESET_BYTE;                         // [R9]
            kbd_en       <= 1'b0;
            timed_out    <= 1'b0;
            rdata        <= RESET_BYTE;
            rvld         <= 1'b0;
            kbd_sync1    <= 1'b0;
            kbd_sync2    <= 1'b0;
            kbd_prev     <= 1'b0;
        end
        else
        begin
            lock_state   <= next_lock_state;
            index        <= next_index;
            ldev         <= next_ldev;
            active       <= next_active;
            unit_cfg     <= next_unit_cfg;
            count_reload <= next_count_reload;
            count        <= next_count;
            kbd_en       <= next_kbd_en;
            timed_out    <= next_timed_out;
            rdata        <= next_rdata;
            rvld         <= next_rvld;
            kbd_sync1    <= kbd_act_in;
            kbd_sync2    <= kbd_sync1;
            kbd_prev     <= kbd_sync2;
        end
    end

    assign io_rdata_out = rdata;
    assign io_rvld_out  = rvld;
    assign timeout_out  = timed_out;                            // [R11]
endmodule

// File: ipw_watchdog_monitor.sv
// Checker for the indexed-port watchdog, bound to its top module.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/100ps
module ipw_watchdog_monitor
    import ipw_pkg::*;
(
    input wire logic       clock_in,     // System clock
    input wire logic       rstn_in,      // Reset, low
    input wire logic [7:0] io_addr_in,   // Port address
    input wire logic [7:0] io_wdata_in,  // Write data
    input wire logic       io_wr_in,     // Write strobe
    input wire logic       io_rd_in,     // Read strobe
    input wire logic       kbd_act_in,   // Keyboard pin
    input wire logic [7:0] io_rdata_out, // Read data
    input wire logic       io_rvld_out,  // Read valid
    input wire logic       timeout_out   // Timeout level
);
    logic [7:0] idx, sel, next_idx, next_sel;
    logic       unl, key, next_unl, next_key;
    logic       dw;
    assign dw = io_wr_in && io_addr_in == DATA_PORT_ADDR;
    // Shadow of lock state and index, so reads can be judged
    always_comb
    begin
        next_idx = idx;
        next_sel = sel;
        next_unl = unl;
        next_key = key;
        if (io_wr_in && io_addr_in == IDX_PORT_ADDR)
        begin
            next_key = io_wdata_in == UNLOCK_KEY;
            if (io_wdata_in == LOCK_KEY)
                next_unl = 1'b0;
            else if (unl)
                next_idx = io_wdata_in;
            else if (key && next_key)
                next_unl = 1'b1;
        end
        if (dw && unl && idx == LDEV_SELECT_IDX)
            next_sel = io_wdata_in;
    end
    always_ff @(posedge clock_in)
    begin
        idx <= rstn_in ? next_idx : 8'h00;
        sel <= rstn_in ? next_sel : 8'h00;
        unl <= rstn_in && next_unl;
        key <= rstn_in && next_key;
    end
    default clocking mon_clk @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);
    chk_read_answer: assert property (io_rd_in && (io_addr_in == IDX_PORT_ADDR ||
        io_addr_in == DATA_PORT_ADDR) |=> io_rvld_out) else $error("read not answered");
    chk_read_cause: assert property (io_rvld_out |-> $past(io_rd_in))
        else $error("read answer without request");
    chk_rdata_idle: assert property (!io_rvld_out |-> io_rdata_out == 8'h00)
        else $error("read data not zero when idle");
    chk_timeout_clear: assert property ($fell(timeout_out) && $past(rstn_in) |->
        $past(dw && io_wdata_in != 8'h00)) else $error("timeout cleared without count write");
    chk_locked_read: assert property (io_rd_in && io_addr_in == DATA_PORT_ADDR && !unl
        |=> io_rdata_out == 8'h00) else $error("locked read returned data");
    chk_locked_hold: assert property (!unl && timeout_out |=> timeout_out)
        else $error("timeout status changed while locked");
    chk_index_read: assert property (io_rd_in && io_addr_in == IDX_PORT_ADDR && unl
        |=> io_rdata_out == idx) else $error("index readback wrong");
    chk_status_read: assert property (io_rvld_out && $past(io_addr_in == DATA_PORT_ADDR
        && unl && idx == WDT_CTRL_IDX && sel == WDT_LDEV_NUM) |-> io_rdata_out[5] == 1'b0
        && io_rdata_out[4] == $past(timeout_out)) else $error("control read wrong");
    chk_unsel_read: assert property (io_rvld_out && $past(io_addr_in == DATA_PORT_ADDR
        && unl && sel != WDT_LDEV_NUM && idx != LDEV_SELECT_IDX) |-> io_rdata_out == 8'h00)
        else $error("unselected register returned data");
endmodule

bind ipw_watchdog ipw_watchdog_monitor u_mon (.clock_in(clock_in), .rstn_in(rstn_in),
    .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in),
    .io_rd_in(io_rd_in), .kbd_act_in(kbd_act_in), .io_rdata_out(io_rdata_out),
    .io_rvld_out(io_rvld_out), .timeout_out(timeout_out));

// File: ipw_host_model.sv
// Host model issuing one-cycle I/O write and read strobes.
// Assumes answers arrive one cycle after the strobe edge.
`timescale 1ns/100ps
module ipw_host_model (
    input  wire logic       clock_in,    // System clock
    input  wire logic [7:0] io_rdata_in, // Read data
    input  wire logic       io_rvld_in,  // Read valid
    output logic      [7:0] io_addr_out, // Port address
    output logic      [7:0] io_wdata_out,// Write data
    output logic            io_wr_out,   // Write strobe
    output logic            io_rd_out    // Read strobe
);
    initial
    begin
        io_addr_out = 8'h00;
        io_wdata_out = 8'h00;
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
    end
    // Index and data go out as separate accesses, index first
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        io_addr_out = a;
        io_wdata_out = d;
        io_wr_out = 1'b1;
        @(posedge clock_in);
        #1;
        io_wr_out = 1'b0;
        // Released bus shows the inverse, not a stale copy
        io_addr_out = ~a;
        io_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        #1;
        io_addr_out = a;
        io_rd_out = 1'b1;
        @(posedge clock_in);
        #1;
        io_rd_out = 1'b0;
        io_addr_out = ~a;
        d = io_rvld_in ? io_rdata_in : 8'hxx;
    endtask
endmodule

// File: ipw_watchdog_bench.sv
// Self-checking bench for the indexed-port watchdog.
// Assumes MS_CYCLES shortened to 4 so every unit but the plain minute fits a short run.
`timescale 1ns/100ps
module ipw_watchdog_bench;
    import ipw_pkg::*;
    localparam int MS = 4;
    logic       clock_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       kbd_act_in = 1'b0;
    logic       io_wr_in, io_rd_in, io_rvld_out, timeout_out;
    logic [7:0] io_addr_in, io_wdata_in, io_rdata_out, d;
    int         err_count = 0;
    int         check_count = 0;
    always #20 clock_in = ~clock_in;
    ipw_host_model host (.clock_in(clock_in), .io_rdata_in(io_rdata_out),
        .io_rvld_in(io_rvld_out), .io_addr_out(io_addr_in), .io_wdata_out(io_wdata_in),
        .io_wr_out(io_wr_in), .io_rd_out(io_rd_in));
    ipw_watchdog #(.MS_CYCLES(MS)) dut (.clock_in(clock_in), .rstn_in(rstn_in),
        .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in), .kbd_act_in(kbd_act_in), .io_rdata_out(io_rdata_out),
        .io_rvld_out(io_rvld_out), .timeout_out(timeout_out));
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkb(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] v);
        host.wr(IDX_PORT_ADDR, i);
        host.wr(DATA_PORT_ADDR, v);
    endtask
    task automatic rreg(input logic [7:0] i, input logic [7:0] e, input string what);
        logic [7:0] v;
        host.wr(IDX_PORT_ADDR, i);
        host.rd(DATA_PORT_ADDR, v);
        chk8(what, e, v);
    endtask
    task automatic unlock;
        host.wr(IDX_PORT_ADDR, UNLOCK_KEY);
        host.wr(IDX_PORT_ADDR, UNLOCK_KEY);
    endtask
    task automatic do_reset;
        rstn_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        rstn_in = 1'b1;
    endtask
    task automatic quiet(input int n);
        logic hi;
        hi = 1'b0;
        repeat (n)
        begin
            @(posedge clock_in);
            #1;
            hi = hi | (timeout_out !== 1'b0);
        end
        chkb("timeout held low", 1'b0, hi);
    endtask
    // Window allows a few cycles of pipeline, less than one ms unit
    task automatic expire(input int c);
        int n;
        n = 0;
        while (timeout_out !== 1'b1 && n <= c + 3)
        begin
            @(posedge clock_in);
            #1;
            n++;
        end
        chkb("timeout delay", 1'b1, n >= c - 1 && n <= c + 3);
    endtask
    task automatic kick(input int n);
        repeat (2 * n)
        begin
            repeat (8) @(posedge clock_in);
            #1;
            kbd_act_in = ~kbd_act_in;
        end
    endtask
    initial
    begin
        #(40 * 20000);
        err_count++;
        test_done;
    end
    initial
    begin
        do_reset;
        host.rd(DATA_PORT_ADDR, d);
        chk8("locked read", 8'h00, d);
        wreg(TIMEOUT_COUNT_IDX, 8'h01);
        unlock;
        rreg(FUNC_ACTIVATE_IDX, 8'h00, "unselected register");
        wreg(LDEV_SELECT_IDX, WDT_LDEV_NUM);
        rreg(LDEV_SELECT_IDX, WDT_LDEV_NUM, "device select");
        host.rd(IDX_PORT_ADDR, d);
        chk8("index readback", LDEV_SELECT_IDX, d);
        rreg(TIMEOUT_COUNT_IDX, 8'h00, "count after reset");
        rreg(FUNC_ACTIVATE_IDX, 8'h00, "activation after reset");
        rreg(8'h40, 8'h00, "unmapped index");
        wreg(COUNT_UNIT_IDX, 8'h10);
        wreg(WDT_CTRL_IDX, 8'h20);
        quiet(40);
        $display("Test access and inactive done");
        wreg(FUNC_ACTIVATE_IDX, 8'h01);
        rreg(FUNC_ACTIVATE_IDX, 8'h01, "activation");
        rreg(COUNT_UNIT_IDX, 8'h10, "unit register");
        wreg(TIMEOUT_COUNT_IDX, 8'h03);
        expire(3 * MS);
        rreg(WDT_CTRL_IDX, 8'h10, "timeout status");
        rreg(TIMEOUT_COUNT_IDX, 8'h00, "count at expiry");
        wreg(TIMEOUT_COUNT_IDX, 8'hff);
        expire(255 * MS);
        wreg(TIMEOUT_COUNT_IDX, 8'hff);
        quiet(500);
        wreg(TIMEOUT_COUNT_IDX, 8'h04);
        expire(4 * MS);
        wreg(TIMEOUT_COUNT_IDX, 8'h05);
        wreg(TIMEOUT_COUNT_IDX, 8'h00);
        quiet(100);
        $display("Test fast count done");
        wreg(COUNT_UNIT_IDX, 8'h00);
        wreg(TIMEOUT_COUNT_IDX, 8'h02);
        repeat (4100) @(posedge clock_in);
        rreg(TIMEOUT_COUNT_IDX, 8'h01, "live count");
        wreg(TIMEOUT_COUNT_IDX, 8'h01);
        expire(1000 * MS);
        wreg(COUNT_UNIT_IDX, 8'h18);
        wreg(TIMEOUT_COUNT_IDX, 8'h02);
        expire(2 * 60 * MS);
        wreg(COUNT_UNIT_IDX, 8'h08);
        wreg(TIMEOUT_COUNT_IDX, 8'h02);
        repeat (4100) @(posedge clock_in);
        rreg(TIMEOUT_COUNT_IDX, 8'h02, "minute count held");
        wreg(TIMEOUT_COUNT_IDX, 8'h00);
        $display("Test units done");
        wreg(COUNT_UNIT_IDX, 8'h10);
        wreg(WDT_CTRL_IDX, 8'h40);
        wreg(TIMEOUT_COUNT_IDX, 8'h08);
        rreg(WDT_CTRL_IDX, 8'h40, "keyboard enable");
        kick(6);
        chkb("timeout with keyboard reload", 1'b0, timeout_out);
        wreg(WDT_CTRL_IDX, 8'h00);
        kick(6);
        chkb("timeout without keyboard reload", 1'b1, timeout_out);
        $display("Test keyboard done");
        wreg(COUNT_UNIT_IDX, 8'h00);
        wreg(TIMEOUT_COUNT_IDX, 8'h02);
        wreg(WDT_CTRL_IDX, 8'h20);
        expire(0);
        rreg(WDT_CTRL_IDX, 8'h10, "forced timeout");
        host.wr(IDX_PORT_ADDR, LOCK_KEY);
        wreg(TIMEOUT_COUNT_IDX, 8'h01);
        chkb("status kept while locked", 1'b1, timeout_out);
        host.rd(DATA_PORT_ADDR, d);
        chk8("read after lock", 8'h00, d);
        $display("Test force and lock done");
        do_reset;
        chkb("timeout after reset", 1'b0, timeout_out);
        host.rd(DATA_PORT_ADDR, d);
        chk8("locked after reset", 8'h00, d);
        unlock;
        wreg(LDEV_SELECT_IDX, WDT_LDEV_NUM);
        rreg(FUNC_ACTIVATE_IDX, 8'h00, "activation after second reset");
        rreg(TIMEOUT_COUNT_IDX, 8'h00, "count after second reset");
        rreg(WDT_CTRL_IDX, 8'h00, "control after second reset");
        $display("Test second reset done");
        test_done;
    end
endmodule
